// >>> rtl/lbh_port.sv
// Local bus host port: strap, arbitration, slave decode, master cycles, DMA
// Operation
// - While PCI reset is active a strap level of 1 sets the bus master enable bit.
// - The port asks for bus ownership on its bus request output.
// - Bus request changes only on a falling edge of the local bus clock.
// - The PCI window select marks a forwarded cycle and is sampled on the falling edge.
// - In DMA cycles a low PCI window select means dual address, a high one single address.
// - The register select marks a register access and is sampled on the falling edge.
// - All data moves over one 32-bit two-way data bus, bits 31 down to 0.
// - As slave, write data is captured without the data strobe as qualifier.
// - As slave, read data is driven without decoding the data strobe.
// - As master, the port drives the data strobe on writes and on reads.
// - An asserted DMA acknowledge marks the cycle as a DMA transfer, not a select access.
// - Fast termination DMA cycles are served through the request and acknowledge pair.
// - The grant input is sampled on the falling local clock edge.
// - DMA request is asserted on a falling edge when the inbound FIFO needs service.
`timescale 1ns/100ps
module lbh_port (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // Local bus pins
    input  wire logic                 i_local_bus_clock,
    input  wire logic                 i_pci_rst_n,
    input  wire logic                 i_master_enable_strap,
    input  wire logic                 i_bus_grant_n,
    input  wire logic                 i_bus_busy_grant_ack_n,
    output logic                      o_bus_busy_grant_ack_n,
    output logic                      o_bus_busy_grant_ack_oe,
    output logic                      o_bus_request_n,
    input  wire logic                 i_pci_window_select_n,
    input  wire logic                 i_register_select_n,
    input  wire logic                 i_address_strobe_n,
    input  wire logic                 i_dma_acknowledge_n,
    output logic                      o_dma_request_n,
    input  wire logic                 i_read_write,
    output logic                      o_read_write,
    output logic                      o_read_write_oe,
    output logic                      o_data_strobe_n,
    output logic                      o_data_strobe_oe,
    input  wire logic [31:0]          i_data,
    output logic      [31:0]          o_data,
    output logic                      o_data_oe,
    // User side
    output logic                      o_bus_master_enable,
    input  wire lbh_pkg::lbh_mst_req_t i_mst_req,
    input  wire logic                 i_mst_ack,
    output logic                      o_mst_done,
    output logic      [31:0]          o_mst_rdata,
    output lbh_pkg::lbh_slv_evt_t     o_slv_evt,
    input  wire logic [31:0]          i_slv_rdata,
    input  wire logic                 i_dma_want
);
    import lbh_pkg::*;

    // ************
    // Pin synchronisers
    // ************
    lbh_pins_t   pins_async;
    lbh_pins_t   pins;
    logic [31:0] data_s;

    assign pins_async = '{
        lclk:          i_local_bus_clock,
        grant_n:       i_bus_grant_n,
        busy_n:        i_bus_busy_grant_ack_n,
        pci_sel_n:     i_pci_window_select_n,
        reg_sel_n:     i_register_select_n,
        addr_strobe_n: i_address_strobe_n,
        dack_n:        i_dma_acknowledge_n,
        read_write:    i_read_write,
        pci_rst_n:     i_pci_rst_n,
        strap:         i_master_enable_strap
    };

    lbh_sync #(
        .WIDTH ($bits(lbh_pins_t)),
        .INIT  (1'b1)
    ) u_sync_pins (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (pins_async),
        .o_sync  (pins)
    );

    lbh_sync #(
        .WIDTH (LBH_DATA_W),
        .INIT  (1'b0)
    ) u_sync_data (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_data),
        .o_sync  (data_s)
    );

    // ************
    // Falling edge of the local bus clock as a one-cycle enable
    // ************
    logic lclk_prev_reg;
    logic fall;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lclk_prev_reg <= 1'b0;
        end else begin
            lclk_prev_reg <= pins.lclk;
        end
    end

    assign fall = lclk_prev_reg & ~pins.lclk;

    // ************
    // Bus master enable strap
    // ************
    logic bme_next;

    // Follows the strap while PCI reset holds, then keeps its value
    assign bme_next = (!pins.pci_rst_n) ? pins.strap : o_bus_master_enable;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bus_master_enable <= LBH_BME_RESET;
        end else begin
            o_bus_master_enable <= bme_next;
        end
    end

    // ************
    // Arbitration
    // ************
    lbh_mst_state_t mst_reg;
    lbh_mst_state_t mst_next;
    logic           own;
    logic           want;

    // Hold the bus while a request waits or a cycle is still open
    assign want = i_mst_req.valid | (mst_reg != MST_IDLE);

    lbh_arbiter u_arbiter (
        .i_clk           (i_clk),
        .i_rst           (i_rst),
        .i_fall          (fall),
        .i_want          (want),
        .i_grant_n       (pins.grant_n),
        .i_busy_n        (pins.busy_n),
        .o_bus_request_n (o_bus_request_n),
        .o_busy_n        (o_bus_busy_grant_ack_n),
        .o_busy_oe       (o_bus_busy_grant_ack_oe),
        .o_own           (own)
    );

    // ************
    // Master cycle sequencer
    // ************
    logic        ack_seen_reg;
    logic        mst_write_reg;
    logic [31:0] mst_wdata_reg;
    logic        mst_active;

    assign mst_active = (mst_reg != MST_IDLE);

    // Address phase, strobe phase, strobe release, then bus turned back
    always_comb begin
        mst_next = mst_reg;
        case (mst_reg)
            MST_IDLE: begin
                if (own && i_mst_req.valid) begin
                    mst_next = MST_ADDR;
                end
            end
            MST_ADDR: begin
                mst_next = MST_STRB;
            end
            MST_STRB: begin
                if (ack_seen_reg) begin
                    mst_next = MST_END;
                end
            end
            MST_END: begin
                mst_next = MST_IDLE;
            end
            default: begin
                mst_next = MST_IDLE;
            end
        endcase
    end

    // Sequencer state and latched request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mst_reg       <= MST_IDLE;
            mst_write_reg <= 1'b0;
            mst_wdata_reg <= LBH_DATA_ZERO;
        end else if (fall) begin
            mst_reg <= mst_next;
            if (mst_reg == MST_IDLE) begin
                mst_write_reg <= i_mst_req.write;
                mst_wdata_reg <= i_mst_req.data;
            end
        end
    end

    // Acknowledge from the same clock is held until the falling edge that ends MST_END
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_seen_reg <= 1'b0;
        end else if (fall && (mst_reg == MST_END)) begin
            ack_seen_reg <= 1'b0;
        end else if (i_mst_ack && (mst_reg == MST_STRB)) begin
            ack_seen_reg <= 1'b1;
        end
    end

    // Data strobe and direction pins while the port is master
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data_strobe_n  <= LBH_PIN_IDLE;
            o_data_strobe_oe <= 1'b0;
            o_read_write     <= LBH_PIN_IDLE;
            o_read_write_oe  <= 1'b0;
        end else if (fall) begin
            o_data_strobe_n  <= ~(mst_next == MST_STRB);
            o_data_strobe_oe <= (mst_next != MST_IDLE);
            o_read_write     <= (mst_next == MST_IDLE) ? LBH_PIN_IDLE :
                                ((mst_reg == MST_IDLE) ? ~i_mst_req.write : ~mst_write_reg);
            o_read_write_oe  <= (mst_next != MST_IDLE);
        end
    end

    // Read data captured as the strobe is released, then done pulses
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mst_rdata <= LBH_DATA_ZERO;
            o_mst_done  <= 1'b0;
        end else begin
            o_mst_done <= fall && (mst_reg == MST_END);
            if (fall && (mst_reg == MST_STRB) && ack_seen_reg && !mst_write_reg) begin
                o_mst_rdata <= data_s;
            end
        end
    end

    // ************
    // Slave decode
    // ************
    logic      sel_pci;
    logic      sel_reg;
    logic      sel_dma;
    logic      slv_cycle;
    logic      slv_seen_reg;
    lbh_kind_t slv_kind;
    logic      slv_read;

    assign sel_dma   = ~pins.dack_n;
    assign sel_pci   = ~pins.pci_sel_n & ~sel_dma;
    assign sel_reg   = ~pins.reg_sel_n & ~sel_dma;
    assign slv_cycle = ~pins.addr_strobe_n & (sel_pci | sel_reg | sel_dma) & ~mst_active;
    assign slv_kind  = sel_dma ? KIND_DMA : (sel_reg ? KIND_REG : KIND_PCI);
    assign slv_read  = slv_cycle & pins.read_write;

    // One event per address strobe, taken at the first falling edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            slv_seen_reg <= 1'b0;
        end else if (pins.addr_strobe_n) begin
            slv_seen_reg <= 1'b0;
        end else if (fall && slv_cycle) begin
            slv_seen_reg <= 1'b1;
        end
    end

    // Slave event; write data taken with no data strobe qualifier
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_slv_evt <= '0;
        end else begin
            o_slv_evt.valid <= fall && slv_cycle && !slv_seen_reg;
            if (fall && slv_cycle && !slv_seen_reg) begin
                o_slv_evt.write     <= ~pins.read_write;
                o_slv_evt.kind      <= slv_kind;
                o_slv_evt.dual_addr <= sel_dma & ~pins.pci_sel_n;
                o_slv_evt.data      <= data_s;
            end
        end
    end

    // ************
    // Data bus drive
    // ************
    logic        drive_mst;
    logic        drive_slv;
    logic [31:0] data_next;

    assign drive_mst = mst_active & mst_write_reg;
    assign drive_slv = slv_read;
    assign data_next = drive_mst ? mst_wdata_reg : i_slv_rdata;

    // Slave read data follows the user side while the cycle is open
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data    <= LBH_DATA_ZERO;
            o_data_oe <= 1'b0;
        end else begin
            o_data    <= data_next;
            o_data_oe <= drive_mst | drive_slv;
        end
    end

    // ************
    // DMA request
    // ************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dma_request_n <= LBH_PIN_IDLE;
        end else if (fall) begin
            o_dma_request_n <= ~i_dma_want;
        end
    end

endmodule

// >>> common/lbh_pkg.sv
// Shared constants and carrier types for the local bus host port
package lbh_pkg;

    // ************
    // Widths and reset values
    // ************
    localparam int   LBH_DATA_W      = 32;
    localparam int   LBH_SYNC_STAGES = 2;
    localparam logic LBH_BME_RESET   = 1'b0;
    localparam logic LBH_PIN_IDLE    = 1'b1;  // Level of an idle active-low pin
    localparam logic [31:0] LBH_DATA_ZERO = 32'h0000_0000;

    // ************
    // State machines
    // ************
    typedef enum logic [4:0] {
        ARB_IDLE = 5'h01,
        ARB_REQ  = 5'h02,
        ARB_WAIT = 5'h04,
        ARB_OWN  = 5'h08,
        ARB_REL  = 5'h10
    } lbh_arb_state_t;

    typedef enum logic [3:0] {
        MST_IDLE = 4'h1,
        MST_ADDR = 4'h2,
        MST_STRB = 4'h4,
        MST_END  = 4'h8
    } lbh_mst_state_t;

    // Kind of a slave cycle seen on the bus
    typedef enum logic [1:0] {
        KIND_PCI = 2'h0,
        KIND_REG = 2'h1,
        KIND_DMA = 2'h2
    } lbh_kind_t;

    // ************
    // Carriers
    // ************
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [LBH_DATA_W-1:0] data;
    } lbh_mst_req_t;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        lbh_kind_t             kind;
        logic                  dual_addr;
        logic [LBH_DATA_W-1:0] data;
    } lbh_slv_evt_t;

    // Control pins, all asynchronous to i_clk
    typedef struct packed {
        logic lclk;
        logic grant_n;
        logic busy_n;
        logic pci_sel_n;
        logic reg_sel_n;
        logic addr_strobe_n;
        logic dack_n;
        logic read_write;
        logic pci_rst_n;
        logic strap;
    } lbh_pins_t;

endpackage

// >>> rtl/lbh_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module lbh_sync #(
    parameter int         WIDTH = 1,
    parameter logic [0:0] INIT  = 1'b1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import lbh_pkg::*;

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= {WIDTH{INIT}};
            o_sync   <= {WIDTH{INIT}};
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// >>> rtl/lbh_arbiter.sv
// Three-wire local bus arbitration for the master side of the port
`timescale 1ns/100ps
module lbh_arbiter (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_fall,
    input  wire logic i_want,
    input  wire logic i_grant_n,
    input  wire logic i_busy_n,
    output logic      o_bus_request_n,
    output logic      o_busy_n,
    output logic      o_busy_oe,
    output logic      o_own
);
    import lbh_pkg::*;

    lbh_arb_state_t state_reg;
    lbh_arb_state_t state_next;

    // ************
    // Next state, moves only on a falling local clock edge
    // ************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ARB_IDLE: begin
                if (i_want) begin
                    state_next = ARB_REQ;
                end
            end
            ARB_REQ: begin
                if (!i_grant_n) begin
                    state_next = ARB_WAIT;
                end
            end
            ARB_WAIT: begin
                if (i_busy_n) begin
                    state_next = ARB_OWN;
                end
            end
            ARB_OWN: begin
                if (!i_want) begin
                    state_next = ARB_REL;
                end
            end
            ARB_REL: begin
                state_next = ARB_IDLE;
            end
            default: begin
                state_next = ARB_IDLE;
            end
        endcase
    end

    // Registered pins; busy is driven high for one period before release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg       <= ARB_IDLE;
            o_bus_request_n <= LBH_PIN_IDLE;
            o_busy_n        <= LBH_PIN_IDLE;
            o_busy_oe       <= 1'b0;
            o_own           <= 1'b0;
        end else if (i_fall) begin
            state_reg       <= state_next;
            o_bus_request_n <= ~((state_next == ARB_REQ) | (state_next == ARB_WAIT));
            o_busy_n        <= ~(state_next == ARB_OWN);
            o_busy_oe       <= (state_next == ARB_OWN) | (state_next == ARB_REL);
            o_own           <= (state_next == ARB_OWN);
        end
    end
endmodule

// >>> testbench/lbh_port_chk.sv
// Concurrent checks on the pins of the local bus host port
`timescale 1ns/100ps
module lbh_port_chk
    import lbh_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_local_bus_clock,
    input  wire logic         i_pci_rst_n,
    input  wire logic         i_master_enable_strap,
    input  wire logic         i_bus_grant_n,
    input  wire logic         i_bus_busy_grant_ack_n,
    input  wire logic         o_bus_busy_grant_ack_n,
    input  wire logic         o_bus_busy_grant_ack_oe,
    input  wire logic         o_bus_request_n,
    input  wire logic         i_pci_window_select_n,
    input  wire logic         i_dma_acknowledge_n,
    input  wire logic         o_dma_request_n,
    input  wire logic         i_dma_want,
    input  wire logic         o_read_write,
    input  wire logic         o_read_write_oe,
    input  wire logic         o_data_strobe_n,
    input  wire logic         o_data_strobe_oe,
    input  wire logic         o_data_oe,
    input  wire logic         o_bus_master_enable,
    input  wire lbh_slv_evt_t o_slv_evt,
    input  wire logic         o_mst_done
);
    logic [2:0] lsync_reg;
    logic       fall;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // ************
    // Falling edge of the local bus clock as the port sees it
    // ************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lsync_reg <= 3'h7;
        end else begin
            lsync_reg <= {lsync_reg[1:0], i_local_bus_clock};
        end
    end
    assign fall = lsync_reg[2] & ~lsync_reg[1];

    // ************
    // Assertions
    // ************
    chk_req_on_fall: assert property ($changed(o_bus_request_n) |->
        ($past(fall) || $past(fall, 2)))
        else $error("bus request moved away from a falling edge");
    chk_bme_set: assert property ((!i_pci_rst_n && i_master_enable_strap) [*8] |=>
        o_bus_master_enable)
        else $error("strap during PCI reset did not set master enable");
    chk_bme_hold: assert property (i_pci_rst_n [*6] |=> $stable(o_bus_master_enable))
        else $error("master enable moved outside PCI reset");
    chk_dma_request_n_on_fall: assert property ($changed(o_dma_request_n) |->
        (($past(fall) || $past(fall, 2)) && o_dma_request_n == !$past(i_dma_want)))
        else $error("DMA request changed wrongly");
    // Busy and grant as the synchronised pins showed them at the owning fall
    chk_own_after_grant: assert property ($rose(o_bus_busy_grant_ack_oe) |->
        !o_bus_busy_grant_ack_n && o_bus_request_n && !$past(i_bus_grant_n, 3)
        && $past(i_bus_busy_grant_ack_n, 3))
        else $error("bus taken without grant or while busy");
    chk_busy_release: assert property ($fell(o_bus_busy_grant_ack_oe) |->
        $past(o_bus_busy_grant_ack_n))
        else $error("busy line not negated before release");
    chk_ds_master: assert property (!o_data_strobe_n |->
        o_data_strobe_oe && o_read_write_oe)
        else $error("data strobe asserted outside a master cycle");
    chk_wr_drive: assert property ((!o_data_strobe_n && !o_read_write) |->
        o_data_oe)
        else $error("master write without data drive");
    chk_slv_no_ds: assert property ((o_data_oe && !o_read_write_oe) |->
        !o_data_strobe_oe)
        else $error("slave read drove the data strobe");
    chk_dma_kind: assert property ((o_slv_evt.valid && !i_dma_acknowledge_n
        && !$past(i_dma_acknowledge_n, 6))
        |-> o_slv_evt.kind == KIND_DMA && o_slv_evt.dual_addr == !i_pci_window_select_n)
        else $error("DMA cycle decoded wrongly");
    chk_done_pulse: assert property (o_mst_done |=> !o_mst_done)
        else $error("master done longer than one cycle");

    cov_own: cover property ($rose(o_bus_busy_grant_ack_oe));
    cov_slave: cover property (o_slv_evt.valid);
    cov_done: cover property (o_mst_done && o_read_write);
endmodule

bind lbh_port lbh_port_chk chk_u (.*);

// >>> testbench/lbh_partner.sv
// Processor and DMA controller side model: clock, arbiter, busy and data lines
`timescale 1ns/100ps
module lbh_partner #(
    parameter logic [31:0] RDATA = 32'h0000_0000
) (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req_n,
    input  wire logic        i_busy_n,
    input  wire logic        i_busy_oe,
    input  wire logic        i_ds_n,
    input  wire logic        i_ds_oe,
    input  wire logic        i_rw,
    input  wire logic        i_dev_oe,
    input  wire logic [31:0] i_dev_data,
    input  wire logic        i_tb_oe,
    input  wire logic [31:0] i_tb_data,
    output logic             o_lclk,
    output logic             o_grant_n,
    output logic             o_busy_n,
    output logic [31:0]      o_data
);
    logic [2:0]  cnt = 3'h0;
    logic [2:0]  hold = 3'h0;
    logic [31:0] idle_pat = 32'h5A5A_A5A5;

    // Free running local clock, eight system clocks a period
    always @(posedge i_clk) begin
        cnt <= cnt + 3'h1;
        idle_pat <= ~idle_pat;
    end
    assign o_lclk = cnt[2];

    // Grant on request; a slow previous owner keeps busy for three periods
    always @(negedge o_lclk) begin
        if (hold != 3'h0) hold <= hold - 3'h1;
        if (!i_req_n && o_grant_n && !(i_busy_oe && !i_busy_n)) begin
            o_grant_n <= 1'b0;
            hold <= i_slow ? 3'h3 : 3'h0;
        end else if (i_busy_oe && !i_busy_n) begin
            o_grant_n <= 1'b1;
        end
    end
    initial o_grant_n = 1'b1;

    // Busy line has a pull-up; undriven data changes every cycle
    assign o_busy_n = (i_busy_oe ? i_busy_n : 1'b1) & (hold == 3'h0);
    assign o_data = i_dev_oe ? i_dev_data : i_tb_oe ? i_tb_data :
                    (i_ds_oe && !i_ds_n && i_rw) ? RDATA : idle_pat;
endmodule

// >>> testbench/lbh_port_tb.sv
// Self-checking bench for the local bus host port
`timescale 1ns/100ps
module lbh_port_tb;
    import lbh_pkg::*;
    localparam logic [31:0] MST_RDATA = 32'hC3A5_0F96;
    logic i_clk, i_rst, i_local_bus_clock, i_pci_rst_n, i_master_enable_strap, i_bus_grant_n;
    logic i_bus_busy_grant_ack_n, o_bus_busy_grant_ack_n, o_bus_busy_grant_ack_oe, o_bus_request_n;
    logic i_pci_window_select_n, i_register_select_n, i_address_strobe_n, i_dma_acknowledge_n;
    logic o_dma_request_n, i_read_write, o_read_write, o_read_write_oe, o_data_strobe_n;
    logic o_data_strobe_oe, o_data_oe, o_bus_master_enable, i_mst_ack, o_mst_done, i_dma_want;
    logic [31:0] i_data, o_data, o_mst_rdata, i_slv_rdata, tb_data;
    logic        tb_oe, slow;
    lbh_mst_req_t i_mst_req;
    lbh_slv_evt_t o_slv_evt;
    int num_errors = 0;
    int total_checks = 0;

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    lbh_port dut_u (.*);
    lbh_partner #(.RDATA(MST_RDATA)) partner_u (.i_clk(i_clk), .i_slow(slow),
        .i_req_n(o_bus_request_n), .i_busy_n(o_bus_busy_grant_ack_n),
        .i_busy_oe(o_bus_busy_grant_ack_oe), .i_ds_n(o_data_strobe_n), .i_ds_oe(o_data_strobe_oe),
        .i_rw(o_read_write), .i_dev_oe(o_data_oe), .i_dev_data(o_data), .i_tb_oe(tb_oe),
        .i_tb_data(tb_data), .o_lclk(i_local_bus_clock), .o_grant_n(i_bus_grant_n),
        .o_busy_n(i_bus_busy_grant_ack_n), .o_data(i_data));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wait_sample(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Strap level sets the enable bit only while PCI reset is held
    task automatic test_strap;
        wait_sample(8);
        check("bme strap high", 32'h1, {31'h0, o_bus_master_enable});
        @(posedge i_clk) i_master_enable_strap <= 1'b0;
        wait_sample(8);
        check("bme strap low", 32'h0, {31'h0, o_bus_master_enable});
        @(posedge i_clk) i_master_enable_strap <= 1'b1;
        wait_sample(8);
        @(posedge i_clk) i_pci_rst_n <= 1'b1;
        wait_sample(8);
        @(posedge i_clk) i_master_enable_strap <= 1'b0;
        wait_sample(8);
        check("bme held", 32'h1, {31'h0, o_bus_master_enable});
    endtask

    // DMA request follows the FIFO need at falling edges
    task automatic test_dma_request_n;
        @(posedge i_clk) i_dma_want <= 1'b1;
        wait_sample(24);
        check("dma request on", 32'h0, {31'h0, o_dma_request_n});
        @(posedge i_clk) i_dma_want <= 1'b0;
        wait_sample(24);
        check("dma request off", 32'h1, {31'h0, o_dma_request_n});
    endtask

    // One slave cycle: one event per address strobe, decoded kind and data
    task automatic slave(input logic p_n, input logic r_n, input logic d_n, input logic rd,
                         input logic [31:0] wd, input lbh_kind_t k, input logic dual);
        int seen;
        lbh_slv_evt_t got;
        seen = 0;
        got = '0;
        @(posedge i_clk);
        i_address_strobe_n <= 1'b0;
        i_pci_window_select_n <= p_n;
        i_register_select_n <= r_n;
        i_dma_acknowledge_n <= d_n;
        i_read_write <= rd;
        tb_data <= wd;
        tb_oe <= !rd;
        i_slv_rdata <= ~wd;
        repeat (24) begin
            wait_sample(1);
            if (o_slv_evt.valid === 1'b1) begin
                seen++;
                got = o_slv_evt;
            end
        end
        check("slave drive", {31'h0, rd}, {31'h0, o_data_oe});
        if (rd) check("slave read data", ~wd, o_data);
        check("strobe idle", 32'h0, {31'h0, o_data_strobe_oe});
        @(posedge i_clk);
        i_address_strobe_n <= 1'b1;
        i_pci_window_select_n <= 1'b1;
        i_register_select_n <= 1'b1;
        i_dma_acknowledge_n <= 1'b1;
        tb_oe <= 1'b0;
        check("event count", 32'h1, 32'(seen));
        check("event kind", {30'h0, k}, {30'h0, got.kind});
        check("event write", {31'h0, !rd}, {31'h0, got.write});
        if (k == KIND_DMA) check("dual address", {31'h0, dual}, {31'h0, got.dual_addr});
        if (!rd) check("slave write data", wd, got.data);
        wait_sample(16);
    endtask

    // One master cycle after arbitration, then release of the bus
    task automatic master(input logic wr, input logic [31:0] wd, input logic sl);
        int n;
        logic saw_req;
        saw_req = 1'b0;
        n = 0;
        @(posedge i_clk);
        slow <= sl;
        i_mst_req <= {1'b1, wr, wd};
        while (o_data_strobe_n !== 1'b0 && n < 400) begin
            wait_sample(1);
            n++;
            if (o_bus_request_n === 1'b0) saw_req = 1'b1;
        end
        check("request seen", 32'h1, {31'h0, saw_req});
        check("busy driven", 32'h0, {31'h0, o_bus_busy_grant_ack_n});
        check("direction", {31'h0, !wr}, {31'h0, o_read_write});
        if (wr) check("master write data", wd, o_data);
        @(posedge i_clk) i_mst_ack <= 1'b1;
        n = 0;
        while (o_mst_done !== 1'b1 && n < 100) begin
            wait_sample(1);
            n++;
        end
        check("master done", 32'h1, {31'h0, o_mst_done});
        if (!wr) check("master read data", MST_RDATA, o_mst_rdata);
        @(posedge i_clk);
        i_mst_ack <= 1'b0;
        i_mst_req <= '0;
        wait_sample(48);
        check("bus released", 32'h0, {31'h0, o_bus_busy_grant_ack_oe});
        check("request idle", 32'h1, {31'h0, o_bus_request_n});
    endtask

    initial begin
        i_rst = 1'b1;
        i_pci_rst_n = 1'b0;
        i_master_enable_strap = 1'b1;
        i_pci_window_select_n = 1'b1;
        i_register_select_n = 1'b1;
        i_address_strobe_n = 1'b1;
        i_dma_acknowledge_n = 1'b1;
        i_read_write = 1'b0;
        i_mst_ack = 1'b0;
        i_dma_want = 1'b0;
        i_mst_req = '0;
        i_slv_rdata = 32'h0000_0000;
        tb_data = 32'h0000_0000;
        tb_oe = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        test_strap();
        test_dma_request_n();
        slave(1'b0, 1'b1, 1'b1, 1'b0, 32'h1234_5678, KIND_PCI, 1'b0);
        slave(1'b1, 1'b0, 1'b1, 1'b1, 32'h0F0F_A5A5, KIND_REG, 1'b0);
        slave(1'b1, 1'b1, 1'b0, 1'b0, 32'h8001_7FFE, KIND_DMA, 1'b0);
        slave(1'b0, 1'b1, 1'b0, 1'b0, 32'hFFFF_0000, KIND_DMA, 1'b1);
        master(1'b1, 32'hA5C3_3C5A, 1'b0);
        master(1'b0, 32'h0000_0000, 1'b1);
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        conclude();
    end
endmodule
